//--- rtl/asp_pkg.sv
// package: register map, field positions and frame constants of the serial port
package asp_pkg;
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFF_MODE = 5'h00;
  localparam logic [4:0] OFF_CTRL = 5'h04;
  localparam logic [4:0] OFF_TXD = 5'h08;
  localparam logic [4:0] OFF_RXD = 5'h0C;
  localparam logic [4:0] OFF_STAT = 5'h10;
  // mode register fields
  localparam int M_SYNC = 0;
  localparam int M_CHR7 = 1;
  localparam int M_PEN = 2;
  localparam int M_ODD = 3;
  localparam int M_STOP2 = 4;
  localparam int M_MPEN = 5;
  localparam int M_HOLD = 7;
  // control register fields
  localparam int C_CKLO = 0;
  localparam int C_CKHI = 1;
  localparam int C_RIE = 4;
  localparam int C_RE = 5;
  localparam int C_TE = 6;
  // status register fields
  localparam int S_TXEMPTY = 0;
  localparam int S_TXDONE = 1;
  localparam int S_RXFULL = 2;
  localparam int S_OVR = 3;
  localparam int S_FER = 4;
  localparam int S_PER = 5;
  localparam int S_RXD = 6;
  localparam int D_MPB = 8;
  // reset values and timing counts
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] OVS_DEF = 8'h10;
  localparam logic [7:0] SYNC_DIV_DEF = 8'h02;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum logic {ST_IDLE, ST_RUN} asp_run_t;
  typedef enum logic [2:0] {SEL_MODE, SEL_CTRL, SEL_TXD, SEL_RXD, SEL_STAT, SEL_NONE} asp_sel_t;
endpackage : asp_pkg

//--- rtl/asp_sync.sv
// three-stage level synchroniser, a bit changes once stages two and three agree
`timescale 1ns/1ps
module asp_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1Reg;
  logic [W-1:0] s2Reg;
  logic [W-1:0] s3Reg;
  logic [W-1:0] outReg;
  logic [W-1:0] outNext;

  always_comb begin
    outNext = outReg;
    for (int i = 0; i < W; i++) begin
      if (s2Reg[i] == s3Reg[i]) begin
        outNext[i] = s3Reg[i];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1Reg <= '0;
      s2Reg <= '0;
      s3Reg <= '0;
      outReg <= '0;
    end else if (ce) begin
      s1Reg <= din;
      s2Reg <= s1Reg;
      s3Reg <= s2Reg;
      outReg <= outNext;
    end
  end

  assign dout = outReg;
endmodule : asp_sync

//--- rtl/asp_bit_timer.sv
// bit timer: marks the middle and the end of each bit period
`timescale 1ns/1ps
module asp_bit_timer (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // control
  input wire logic restart,
  input wire logic [7:0] len,
  // ticks
  output logic half,
  output logic full
);
  logic [7:0] cntReg;
  logic [7:0] cntNext;

  always_comb begin
    half = (cntReg == ((len >> 1) - 8'h01));
    full = (cntReg == (len - 8'h01));
    if (restart || full) begin
      cntNext = 8'h00;
    end else begin
      cntNext = cntReg + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cntReg <= 8'h00;
    end else if (ce) begin
      cntReg <= cntNext;
    end
  end
endmodule : asp_bit_timer

//--- rtl/asp_serial_port.sv
// serial port top: register slave on ref_clk, frame engines on the link clock
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module asp_serial_port
  import asp_pkg::*;
#(
  parameter logic [7:0] ASYNC_DIV = OVS_DEF,
  parameter logic [7:0] SYNC_DIV = SYNC_DIV_DEF
) (
  // clocks, reset, enable
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic linkClk,
  // register bus
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // serial pins
  input wire logic rxdIn,
  output logic txdOut,
  output logic sckOut,
  output logic sckOeN,
  // requests
  output logic rxFullReq,
  output logic rxErrReq
);
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] ctrl;
    logic [8:0] txData;
    logic txTog;
    logic txEmpty;
    logic txDone;
    logic [8:0] rxHold;
    logic rxFull;
    logic ovr;
    logic fer;
    logic parity_error_flag;
    logic ackSeen;
    logic rxSeen;
    logic reqFull;
    logic reqErr;
    logic awOk;
    logic [ADDR_W-1:0] awAddr;
    logic wOk;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awRdy;
    logic wRdy;
    logic bValid;
    logic [1:0] bResp;
    logic arRdy;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } asp_sys_t;

  typedef struct packed {
    asp_run_t txSt;
    logic [12:0] txSh;
    logic [3:0] txLeft;
    logic txOwn;
    logic txSeen;
    logic txd;
    logic ackTog;
    logic sck;
    logic sckOeN;
    asp_run_t rxSt;
    logic rxVer;
    logic [11:0] rxSh;
    logic [3:0] rxLeft;
    logic rxPrev;
    logic [8:0] rxWord;
    logic rxPerr;
    logic rxFerr;
    logic rxTog;
  } asp_link_t;

  localparam asp_sys_t SYS_RST = '{mode: MODE_RST, ctrl: CTRL_RST, txEmpty: 1'b1,
    txDone: 1'b1, awRdy: 1'b1, wRdy: 1'b1, arRdy: 1'b1, default: '0};
  localparam asp_link_t LINK_RST = '{txSt: ST_IDLE, rxSt: ST_IDLE, txd: 1'b1, sck: 1'b1,
    sckOeN: 1'b1, rxPrev: 1'b1, default: '0};

  asp_sys_t sysReg;
  asp_sys_t sysNext;
  asp_link_t lnkReg;
  asp_link_t lnkNext;
  logic [2:0] sysIn;
  logic [17:0] lnkIn;
  logic linkCe;
  logic txHalf;
  logic txFull;
  logic rxHalf;
  logic rxFull;
  logic rxRestart;
  logic [7:0] bitLen;

  ////////////////////////////////////////////////////////////////////////////
  // frame helpers

  function automatic asp_sel_t regSel(input logic [ADDR_W-1:0] a);
    case (a)
      OFF_MODE: regSel = SEL_MODE;
      OFF_CTRL: regSel = SEL_CTRL;
      OFF_TXD: regSel = SEL_TXD;
      OFF_RXD: regSel = SEL_RXD;
      OFF_STAT: regSel = SEL_STAT;
      default: regSel = SEL_NONE;
    endcase
  endfunction : regSel

  // data, parity and multiprocessor bits of an asynchronous character
  function automatic logic [3:0] dataBits(input logic [7:0] m);
    dataBits = (m[M_CHR7] ? 4'h7 : 4'h8)
      + {3'h0, m[M_PEN] & ~m[M_MPEN]} + {3'h0, m[M_MPEN]};
  endfunction : dataBits

  function automatic logic [12:0] txFrame(input logic [7:0] m, input logic [8:0] d);
    logic [12:0] f;
    logic [3:0] p;
    logic [7:0] dm;
    f = 13'h1FFF;
    p = m[M_CHR7] ? 4'h7 : 4'h8;
    dm = m[M_CHR7] ? {1'b0, d[6:0]} : d[7:0];
    if (m[M_SYNC]) begin
      f[7:0] = d[7:0];
    end else begin
      f[0] = 1'b0;
      for (int i = 0; i < 8; i++) begin
        if (i < int'(p)) begin
          f[i+1] = d[i];
        end
      end
      if (m[M_MPEN]) begin
        f[p+4'h1] = d[D_MPB];
      end else if (m[M_PEN]) begin
        f[p+4'h1] = ^dm ^ m[M_ODD];
      end
    end
    txFrame = f;
  endfunction : txFrame

  ////////////////////////////////////////////////////////////////////////////
  // clock domain crossings

  asp_sync #(.W(3)) uSysSync (
    .clk(ref_clk),
    .rst(sys_rst),
    .ce(clkEn),
    .din({rxdIn, lnkReg.ackTog, lnkReg.rxTog}),
    .dout(sysIn)
  );

  asp_sync #(.W(1)) uCeSync (
    .clk(linkClk),
    .rst(sys_rst),
    .ce(1'b1),
    .din(clkEn),
    .dout(linkCe)
  );

  // config crosses as levels; software changes it only between frames
  asp_sync #(.W(18)) uLnkSync (
    .clk(linkClk),
    .rst(sys_rst),
    .ce(linkCe),
    .din({rxdIn, sysReg.txTog, sysReg.ctrl, sysReg.mode}),
    .dout(lnkIn)
  );

  assign bitLen = lnkIn[M_SYNC] ? SYNC_DIV : ASYNC_DIV;

  asp_bit_timer uTxTim (
    .clk(linkClk),
    .rst(sys_rst),
    .ce(linkCe),
    .restart(1'b0),
    .len(bitLen),
    .half(txHalf),
    .full(txFull)
  );

  asp_bit_timer uRxTim (
    .clk(linkClk),
    .rst(sys_rst),
    .ce(linkCe),
    .restart(rxRestart),
    .len(bitLen),
    .half(rxHalf),
    .full(rxFull)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register side

  always_comb begin
    sysNext = sysReg;
    if (awvalid && sysReg.awRdy) begin
      sysNext.awOk = 1'b1;
      sysNext.awAddr = awaddr;
    end
    if (wvalid && sysReg.wRdy) begin
      sysNext.wOk = 1'b1;
      sysNext.wData = wdata;
      sysNext.wStrb = wstrb;
    end
    if (sysReg.bValid && bready) begin
      sysNext.bValid = 1'b0;
    end
    if (sysReg.rValid && rready) begin
      sysNext.rValid = 1'b0;
    end
    if (arvalid && sysReg.arRdy) begin
      sysNext.rValid = 1'b1;
      sysNext.rResp = RESP_OK;
      sysNext.rData = 32'h00000000;
      case (regSel(araddr))
        SEL_MODE: sysNext.rData[7:0] = sysReg.mode;
        SEL_CTRL: sysNext.rData[7:0] = sysReg.ctrl;
        SEL_TXD: sysNext.rData[8:0] = sysReg.txData;
        SEL_RXD: begin
          // reading the character consumes it
          sysNext.rData[8:0] = sysReg.rxHold;
          sysNext.rxFull = 1'b0;
        end
        SEL_STAT: begin
          sysNext.rData[S_TXEMPTY] = sysReg.txEmpty;
          sysNext.rData[S_TXDONE] = sysReg.txDone;
          sysNext.rData[S_RXFULL] = sysReg.rxFull;
          sysNext.rData[S_OVR] = sysReg.ovr;
          sysNext.rData[S_FER] = sysReg.fer;
          sysNext.rData[S_PER] = sysReg.parity_error_flag;
          sysNext.rData[S_RXD] = sysIn[2];
        end
        default: sysNext.rResp = RESP_ERR;
      endcase
    end
    if (sysReg.awOk && sysReg.wOk && !sysReg.bValid) begin
      sysNext.awOk = 1'b0;
      sysNext.wOk = 1'b0;
      sysNext.bValid = 1'b1;
      sysNext.bResp = RESP_OK;
      case (regSel(sysReg.awAddr))
        SEL_MODE: begin
          if (sysReg.wStrb[0]) begin
            sysNext.mode = sysReg.wData[7:0];
          end
        end
        SEL_CTRL: begin
          if (sysReg.wStrb[0]) begin
            sysNext.ctrl = sysReg.wData[7:0];
          end
        end
        SEL_TXD: begin
          // a write while the buffer is busy or transmit is off is dropped
          if (sysReg.wStrb[0] && sysReg.txEmpty && sysReg.ctrl[C_TE]) begin
            sysNext.txData = sysReg.wData[8:0];
            sysNext.txEmpty = 1'b0;
            sysNext.txDone = 1'b0;
            sysNext.txTog = ~sysReg.txTog;
          end
        end
        SEL_STAT: begin
          if (sysReg.wStrb[0]) begin
            sysNext.rxFull = sysNext.rxFull & ~sysReg.wData[S_RXFULL];
            sysNext.ovr = sysReg.ovr & ~sysReg.wData[S_OVR];
            sysNext.fer = sysReg.fer & ~sysReg.wData[S_FER];
            sysNext.parity_error_flag = sysReg.parity_error_flag & ~sysReg.wData[S_PER];
          end
        end
        SEL_RXD: sysNext.bResp = RESP_OK;
        default: sysNext.bResp = RESP_ERR;
      endcase
    end
    // link events come after the clears so that a set in the same cycle wins
    if (sysIn[1] != sysReg.ackSeen) begin
      sysNext.ackSeen = sysIn[1];
      sysNext.txEmpty = 1'b1;
      sysNext.txDone = 1'b1;
    end
    if (sysIn[0] != sysReg.rxSeen) begin
      sysNext.rxSeen = sysIn[0];
      if (sysNext.rxFull) begin
        sysNext.ovr = 1'b1;
      end else begin
        sysNext.rxHold = lnkReg.rxWord;
        sysNext.rxFull = 1'b1;
        sysNext.parity_error_flag = sysNext.parity_error_flag | lnkReg.rxPerr;
        sysNext.fer = sysNext.fer | lnkReg.rxFerr;
      end
    end
    // errored characters never call the transfer unit
    sysNext.reqFull = sysNext.rxFull & sysNext.ctrl[C_RIE]
      & ~(sysNext.ovr | sysNext.parity_error_flag | sysNext.fer);
    sysNext.reqErr = sysNext.ovr | sysNext.parity_error_flag | sysNext.fer;
    sysNext.awRdy = ~sysNext.awOk & ~sysNext.bValid;
    sysNext.wRdy = ~sysNext.wOk & ~sysNext.bValid;
    sysNext.arRdy = ~sysNext.rValid;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sysReg <= SYS_RST;
    end else if (clkEn) begin
      sysReg <= sysNext;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link side

  always_comb begin
    logic [7:0] m;
    logic [7:0] c;
    logic rxd;
    logic [3:0] db;
    logic [3:0] dl;
    logic [11:0] sh;
    logic [11:0] v;
    logic [7:0] dat;
    logic fixedClk;
    logic freeClk;
    logic [12:0] fr;
    m = lnkIn[7:0];
    c = lnkIn[15:8];
    rxd = lnkIn[17];
    db = dataBits(m);
    dl = m[M_CHR7] ? 4'h7 : 4'h8;
    sh = {rxd, lnkReg.rxSh[11:1]};
    v = sh >> (4'hC - (db + 4'h1));
    dat = 8'h00;
    fixedClk = m[M_HOLD] & ~c[C_CKLO];
    freeClk = m[M_HOLD] & c[C_CKLO];
    fr = txFrame(m, sysReg.txData);
    lnkNext = lnkReg;
    rxRestart = 1'b0;
    lnkNext.rxPrev = rxd;
    lnkNext.sckOeN = ~(m[M_SYNC] | m[M_HOLD]);
    // transmit engine, also the clock source of synchronous frames
    case (lnkReg.txSt)
      ST_IDLE: begin
        if (txFull && c[C_TE] && lnkIn[16] != lnkReg.txSeen) begin
          lnkNext.txSeen = lnkIn[16];
          lnkNext.txOwn = 1'b1;
          lnkNext.txSt = ST_RUN;
          lnkNext.txSh = fr >> 1;
          lnkNext.txd = fr[0];
          lnkNext.txLeft = m[M_SYNC] ? 4'h7
            : 4'h1 + db + {3'h0, m[M_STOP2]};
        end else if (txFull && m[M_SYNC] && c[C_RE] && !c[C_TE]) begin
          // receive-only synchronous frames keep the clock running
          lnkNext.txOwn = 1'b0;
          lnkNext.txSt = ST_RUN;
          lnkNext.txSh = 13'h1FFF;
          lnkNext.txd = 1'b1;
          lnkNext.txLeft = 4'h7;
        end
      end
      ST_RUN: begin
        if (txHalf && m[M_SYNC]) begin
          lnkNext.rxSh = sh;
        end
        if (txFull) begin
          if (lnkReg.txLeft == 4'h0) begin
            lnkNext.txSt = ST_IDLE;
            lnkNext.txd = 1'b1;
            if (lnkReg.txOwn) begin
              lnkNext.ackTog = ~lnkReg.ackTog;
            end
            if (m[M_SYNC] && c[C_RE]) begin
              lnkNext.rxWord = {1'b0, lnkReg.rxSh[11:4]};
              lnkNext.rxPerr = 1'b0;
              lnkNext.rxFerr = 1'b0;
              lnkNext.rxTog = ~lnkReg.rxTog;
            end
          end else begin
            lnkNext.txd = lnkReg.txSh[0];
            lnkNext.txSh = {1'b1, lnkReg.txSh[12:1]};
            lnkNext.txLeft = lnkReg.txLeft - 4'h1;
          end
        end
      end
      default: lnkNext.txSt = ST_IDLE;
    endcase
    // clock pin only moves on timer ticks, so no pulse is under half a bit
    if (txFull) begin
      if (fixedClk) begin
        lnkNext.sck = c[C_CKHI];
      end else begin
        lnkNext.sck = ~(freeClk | (m[M_SYNC] & (lnkNext.txSt == ST_RUN)));
      end
    end else if (txHalf) begin
      lnkNext.sck = fixedClk ? c[C_CKHI] : 1'b1;
    end
    // asynchronous receiver, samples each bit at its middle
    case (lnkReg.rxSt)
      ST_IDLE: begin
        if (!m[M_SYNC] && c[C_RE] && lnkReg.rxPrev && !rxd) begin
          rxRestart = 1'b1;
          lnkNext.rxSt = ST_RUN;
          lnkNext.rxVer = 1'b1;
          lnkNext.rxLeft = db + 4'h1;
        end
      end
      ST_RUN: begin
        if (rxHalf) begin
          if (lnkReg.rxVer) begin
            // a start bit shorter than half a bit is a glitch
            lnkNext.rxVer = 1'b0;
            if (rxd) begin
              lnkNext.rxSt = ST_IDLE;
            end
          end else begin
            lnkNext.rxSh = sh;
            lnkNext.rxLeft = lnkReg.rxLeft - 4'h1;
            if (lnkReg.rxLeft == 4'h1) begin
              for (int i = 0; i < 8; i++) begin
                if (i < int'(dl)) begin
                  dat[i] = v[i];
                end
              end
              lnkNext.rxSt = ST_IDLE;
              lnkNext.rxWord = {m[M_MPEN] & v[dl], dat};
              lnkNext.rxPerr = m[M_PEN] & ~m[M_MPEN]
                & ((^dat ^ v[dl]) != m[M_ODD]);
              lnkNext.rxFerr = ~v[db];
              lnkNext.rxTog = ~lnkReg.rxTog;
            end
          end
        end
      end
      default: lnkNext.rxSt = ST_IDLE;
    endcase
  end

  always_ff @(posedge linkClk or posedge sys_rst) begin
    if (sys_rst) begin
      lnkReg <= LINK_RST;
    end else if (linkCe) begin
      lnkReg <= lnkNext;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign awready = sysReg.awRdy;
  assign wready = sysReg.wRdy;
  assign bvalid = sysReg.bValid;
  assign bresp = sysReg.bResp;
  assign arready = sysReg.arRdy;
  assign rvalid = sysReg.rValid;
  assign rdata = sysReg.rData;
  assign rresp = sysReg.rResp;
  assign rxFullReq = sysReg.reqFull;
  assign rxErrReq = sysReg.reqErr;
  assign txdOut = lnkReg.txd;
  assign sckOut = lnkReg.sck;
  assign sckOeN = lnkReg.sckOeN;
endmodule : asp_serial_port

//--- sim/asp_serial_port_monitor.sv
// checker: bus handshakes and request relations at the serial port pins
`timescale 1ns/1ps
module asp_serial_port_monitor
  import asp_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  // requests
  input wire logic rxFullReq,
  input wire logic rxErrReq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////////
  wr_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write not answered in time");
  rd_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered in time");
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped early");
  wr_refuse_a: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  rd_refuse_a: assert property (rvalid |-> !arready)
    else $error("read taken while data pending");
  rd_release_a: assert property (rvalid && rready |=> !rvalid)
    else $error("read data held after handshake");
  err_data_a: assert property (rvalid && rresp == RESP_ERR |-> rdata == 32'h0000_0000)
    else $error("error response carries data");
  full_vs_err_a: assert property (rxFullReq |-> !rxErrReq)
    else $error("full request raised beside error");
endmodule : asp_serial_port_monitor

bind asp_serial_port asp_serial_port_monitor MON (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
  .rready(rready), .rxFullReq(rxFullReq), .rxErrReq(rxErrReq)
);

//--- sim/asp_link_partner.sv
// link partner: sends receive frames and captures transmit frames
`timescale 1ns/1ps
module asp_link_partner #(
  parameter int BITLEN = 16
) (
  // link clock
  input wire logic linkClk,
  // serial lines
  input wire logic txdOut,
  output logic rxdIn
);
  initial rxdIn = 1'b1;
  // start bit, then n bits lsb first, line left at endLvl
  task automatic send(input logic [11:0] bits, input int n, input logic endLvl);
    @(posedge linkClk);
    rxdIn <= 1'b0;
    repeat (BITLEN) @(posedge linkClk);
    for (int i = 0; i < n; i++) begin
      rxdIn <= bits[i];
      repeat (BITLEN) @(posedge linkClk);
    end
    rxdIn <= endLvl;
  endtask : send
  task automatic line(input logic lvl);
    @(posedge linkClk);
    rxdIn <= lvl;
  endtask : line
  // samples mid-bit after the start edge
  task automatic grab(output logic [11:0] bits, input int n);
    bits = 12'h000;
    @(negedge txdOut);
    repeat (BITLEN / 2) @(posedge linkClk);
    for (int i = 0; i < n; i++) begin
      repeat (BITLEN) @(posedge linkClk);
      bits[i] = txdOut;
    end
  endtask : grab
endmodule : asp_link_partner

//--- sim/asp_serial_port_bench.sv
// testbench: register sequences against the serial port and a link partner
`timescale 1ns/1ps
module asp_serial_port_bench;
  import asp_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clkEn = 1'b1;
  logic linkClk = 1'b0;
  logic [4:0] awaddr = 5'h00;
  logic [4:0] araddr = 5'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  wire logic awready, wready, bvalid, arready, rvalid;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic rxdIn, txdOut, sckOut, sckOeN, rxFullReq, rxErrReq;
  int num_errors = 0;
  int n_compared = 0;
  logic [31:0] d;
  logic [1:0] resp;
  logic [11:0] got;
  int nHi;

  asp_serial_port DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .clkEn(clkEn), .linkClk(linkClk),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .rxdIn(rxdIn), .txdOut(txdOut), .sckOut(sckOut),
    .sckOeN(sckOeN), .rxFullReq(rxFullReq), .rxErrReq(rxErrReq));
  asp_link_partner LP (.linkClk(linkClk), .txdOut(txdOut), .rxdIn(rxdIn));

  always #5 ref_clk = ~ref_clk;
  // odd start offset keeps the link clock out of phase with ref_clk
  initial begin
    #7.3;
    forever #15 linkClk = ~linkClk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (num_errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // outputs sampled at negedge, released at the next rising edge
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    logic ah;
    logic wh;
    logic bh;
    ah = 1'b0;
    wh = 1'b0;
    bh = 1'b0;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bh) begin
      @(negedge ref_clk);
      ah = ah | awready;
      wh = wh | wready;
      bh = bvalid;
      @(posedge ref_clk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) bready <= 1'b0;
    end
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [31:0] v, output logic [1:0] r);
    logic ah;
    logic rh;
    ah = 1'b0;
    rh = 1'b0;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rh) begin
      @(negedge ref_clk);
      ah = ah | arready;
      rh = rvalid;
      v = rdata;
      r = rresp;
      @(posedge ref_clk);
      if (ah) arvalid <= 1'b0;
      if (rh) rready <= 1'b0;
    end
  endtask : rd
  task automatic rb(input logic [4:0] a, input int b, input logic e);
    logic [31:0] v;
    logic [1:0] r;
    rd(a, v, r);
    chk(v[b], e);
  endtask : rb
  task automatic rx(input logic [7:0] dt, input logic pb, input logic stp, input logic endl);
    LP.send({2'b11, stp, pb, dt}, 10, endl);
    repeat (40) @(negedge ref_clk);
  endtask : rx
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #900000;
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (20) @(posedge ref_clk);
    rd(OFF_MODE, d, resp);
    chk(d, MODE_RST);
    rd(OFF_CTRL, d, resp);
    chk(d, CTRL_RST);
    rb(OFF_STAT, S_TXDONE, 1'b1);
    rd(5'h14, d, resp);
    chk(resp, RESP_ERR);
    wr(OFF_MODE, 1 << M_PEN);
    wr(OFF_CTRL, (1 << C_RE) | (1 << C_RIE));
    rx(8'hA5, ^8'hA5, 1'b1, 1'b1);
    chk(rxFullReq, 1'b1);
    chk(rxErrReq, 1'b0);
    rd(OFF_RXD, d, resp);
    chk(d, 32'h0000_00A5);
    repeat (8) @(negedge ref_clk);
    chk(rxFullReq, 1'b0);
    rx(8'h3C, ~^8'h3C, 1'b1, 1'b1);
    chk(rxErrReq, 1'b1);
    chk(rxFullReq, 1'b0);
    rb(OFF_STAT, S_PER, 1'b1);
    rb(OFF_STAT, S_RXFULL, 1'b1);
    rd(OFF_RXD, d, resp);
    chk(d, 32'h0000_003C);
    wr(OFF_STAT, 32'h0000_003C);
    repeat (8) @(negedge ref_clk);
    chk(rxErrReq, 1'b0);
    wr(OFF_CTRL, 1 << C_RE);
    rx(8'h5A, ^8'h5A, 1'b1, 1'b1);
    rb(OFF_STAT, S_RXFULL, 1'b1);
    chk(rxFullReq, 1'b0);
    rx(8'hC3, ^8'hC3, 1'b1, 1'b1);
    rb(OFF_STAT, S_OVR, 1'b1);
    chk(rxErrReq, 1'b1);
    rd(OFF_RXD, d, resp);
    chk(d, 32'h0000_005A);
    wr(OFF_STAT, 32'h0000_003C);
    // stop bit low, then the line stays low as a break
    rx(8'h66, ^8'h66, 1'b0, 1'b0);
    rb(OFF_STAT, S_FER, 1'b1);
    rb(OFF_STAT, S_RXD, 1'b0);
    LP.line(1'b1);
    repeat (600) @(negedge ref_clk);
    wr(OFF_STAT, 32'h0000_003C);
    rb(OFF_STAT, S_RXD, 1'b1);
    rd(OFF_RXD, d, resp);
    wr(OFF_MODE, 1 << M_MPEN);
    rx(8'h81, 1'b1, 1'b1, 1'b1);
    rd(OFF_RXD, d, resp);
    chk(d, 32'h0000_0181);
    wr(OFF_MODE, (1 << M_CHR7) | (1 << M_PEN) | (1 << M_ODD) | (1 << M_STOP2));
    wr(OFF_CTRL, 1 << C_TE);
    fork
      LP.grab(got, 10);
      wr(OFF_TXD, 32'h0000_0055);
    join
    chk(got, {2'b00, 2'b11, ~^7'h55, 7'h55});
    for (int i = 0; i < 100; i++) begin
      rd(OFF_STAT, d, resp);
      if (d[S_TXDONE] === 1'b1) break;
    end
    chk(d[S_TXDONE], 1'b1);
    wr(OFF_CTRL, 32'h0000_0000);
    wr(OFF_MODE, 1 << M_SYNC);
    // mode needs up to five link edges to cross and reach the pin
    repeat (30) @(negedge ref_clk);
    chk(sckOeN, 1'b0);
    wr(OFF_CTRL, 1 << C_TE);
    // line is stable at each rising serial clock edge
    fork
      repeat (8) begin
        @(posedge sckOut);
        got = {txdOut, got[11:1]};
      end
      wr(OFF_TXD, 32'h0000_00A6);
    join
    chk(got[11:4], 8'hA6);
    wr(OFF_MODE, 1 << M_HOLD);
    repeat (200) @(negedge ref_clk);
    chk(sckOut, 1'b0);
    chk(sckOeN, 1'b0);
    wr(OFF_CTRL, 1 << C_CKHI);
    repeat (200) @(negedge ref_clk);
    chk(sckOut, 1'b1);
    wr(OFF_CTRL, 1 << C_CKLO);
    nHi = 0;
    repeat (300) begin
      @(negedge ref_clk);
      nHi += sckOut;
    end
    chk(nHi > 100 && nHi < 200, 1'b1);
    finish_test();
  end
endmodule : asp_serial_port_bench
